// file: dv/dual_timer_counter_modes_tb.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
module dual_timer_counter_modes_tb;
  logic CLK, NRST, PSEL, PENABLE, PWRITE, EXT_COUNT_PIN, PREADY, PSLVERR, TIMER_IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [1:0] INT_ACK, OVF_FLAG;
  logic [7:0] q;
  logic e;
  int fail_count, samples_checked;
  tmr_top i_tmr_top (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .EXT_COUNT_PIN, .INT_ACK, .OVF_FLAG, .TIMER_IRQ);
  // 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // compare and count
  task chk(input logic [7:0] s, input logic [7:0] x);
    samples_checked++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task close_out;
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // one apb transfer, held until pready is sampled high
  task xf(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    q = PRDATA[7:0];
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    xf(1'b1, {2'h0, i, 2'h0}, d);
  endtask
  task rk(input logic [7:0] i, input logic [7:0] x);
    xf(1'b0, {2'h0, i, 2'h0}, 8'h00);
    chk(q, x);
  endtask
  // wait a bounded time for an overflow flag
  task wflag(input int b);
    int n;
    n = 0;
    while (OVF_FLAG[b] !== 1'b1 && n < 600) begin
      @(posedge CLK);
      n++;
    end
    chk({7'h0, OVF_FLAG[b]}, 8'h01);
  endtask
  task t_regs;
    rk(`TMR_IDX_AUX, 8'h00);
    rk(`TMR_IDX_CTRL, 8'h00);
    wr(`TMR_IDX_MODE, 8'h02);
    wr(`TMR_IDX_AUX, 8'h01);
    rk(`TMR_IDX_AUX, 8'h01);
    wr(`TMR_IDX_AUX, 8'h00);
    wr(`TMR_IDX_MODE, 8'hff);
    rk(`TMR_IDX_MODE, 8'h37);
    rk(8'h80, 8'h00);
    chk({7'h0, e}, 8'h01);
    xf(1'b0, 12'h222, 8'h00);
    chk({7'h0, e}, 8'h01);
  endtask
  // 13-bit count with prescaler, then interrupt and service
  task t_mode0;
    wr(`TMR_IDX_MODE, 8'h00);
    wr(`TMR_IDX_CNT0_LO, 8'h1e);
    wr(`TMR_IDX_CNT0_HI, 8'hff);
    wr(`TMR_IDX_CTRL, 8'h10);
    wflag(0);
    wr(`TMR_IDX_CTRL, 8'h20);
    rk(`TMR_IDX_CNT0_HI, 8'h00);
    xf(1'b0, {2'h0, `TMR_IDX_CNT0_LO, 2'h0}, 8'h00);
    chk({7'h0, q[4:0] < 5'h10}, 8'h01);
    wr(`TMR_IDX_IRQ_EN, 8'h01);
    @(negedge CLK);
    chk({7'h0, TIMER_IRQ}, 8'h01);
    rk(`TMR_IDX_IRQ_STAT, 8'h01);
    wr(`TMR_IDX_IRQ_EN, 8'h00);
    @(negedge CLK);
    chk({7'h0, TIMER_IRQ}, 8'h00);
    wr(`TMR_IDX_IRQ_EN, 8'h01);
    wr(`TMR_IDX_IRQ_CLR, 8'h01);
    @(negedge CLK);
    chk({7'h0, TIMER_IRQ}, 8'h00);
    @(posedge CLK);
    INT_ACK <= 2'h1;
    @(posedge CLK);
    INT_ACK <= 2'h0;
    @(negedge CLK);
    chk({7'h0, OVF_FLAG[0]}, 8'h00);
  endtask
  // 16-bit cascade holds while stopped, then wraps to zero on overflow
  task t_mode1;
    wr(`TMR_IDX_MODE, 8'h10);
    wr(`TMR_IDX_CNT1_LO, 8'hfd);
    wr(`TMR_IDX_CNT1_HI, 8'hff);
    cyc(5);
    rk(`TMR_IDX_CNT1_LO, 8'hfd);
    wr(`TMR_IDX_CTRL, 8'h40);
    wflag(1);
    wr(`TMR_IDX_CTRL, 8'h00);
    @(negedge CLK);
    chk({7'h0, OVF_FLAG[1]}, 8'h00);
    rk(`TMR_IDX_CNT1_HI, 8'h00);
    xf(1'b0, {2'h0, `TMR_IDX_CNT1_LO, 2'h0}, 8'h00);
    chk({7'h0, q < 8'h20}, 8'h01);
  endtask
  // auto-reload from the high byte
  task t_rl(input logic [7:0] lo, hi, md, ax, run, input int b);
    wr(`TMR_IDX_MODE, md);
    wr(`TMR_IDX_AUX, ax);
    wr(lo, 8'hfe);
    wr(hi, 8'hf0);
    wr(`TMR_IDX_CTRL, run);
    wflag(b);
    wr(`TMR_IDX_CTRL, 8'h00);
    rk(hi, 8'hf0);
    xf(1'b0, {2'h0, lo, 2'h0}, 8'h00);
    chk({7'h0, q >= 8'hf0}, 8'h01);
    wr(`TMR_IDX_AUX, 8'h00);
  endtask
  // falling edges of the pin counted
  task t_count;
    wr(`TMR_IDX_MODE, 8'h05);
    wr(`TMR_IDX_CNT0_LO, 8'h00);
    wr(`TMR_IDX_CNT0_HI, 8'h00);
    wr(`TMR_IDX_CTRL, 8'h10);
    repeat (3) begin
      EXT_COUNT_PIN <= 1'b0;
      cyc(4);
      EXT_COUNT_PIN <= 1'b1;
      cyc(4);
    end
    cyc(4);
    wr(`TMR_IDX_CTRL, 8'h00);
    rk(`TMR_IDX_CNT0_LO, 8'h03);
  endtask
  task t_halt;
    wr(`TMR_IDX_MODE, 8'h30);
    wr(`TMR_IDX_CNT1_LO, 8'h05);
    wr(`TMR_IDX_CTRL, 8'h40);
    cyc(10);
    wr(`TMR_IDX_CTRL, 8'h00);
    rk(`TMR_IDX_CNT1_LO, 8'h05);
  endtask
  // main sequence
  initial begin
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    EXT_COUNT_PIN = 1'b1;
    INT_ACK = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    cyc(20);
    NRST <= 1'b1;
    cyc(4);
    t_regs;
    t_mode0;
    t_mode1;
    t_rl(`TMR_IDX_CNT1_LO, `TMR_IDX_CNT1_HI, 8'h20, 8'h00, 8'h40, 1);
    t_rl(`TMR_IDX_CNT0_LO, `TMR_IDX_CNT0_HI, 8'h02, 8'h01, 8'h10, 0);
    t_count;
    t_halt;
    close_out;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    close_out;
  end
endmodule // dual_timer_counter_modes_tb

// file: dv/tmr_props.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_props (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // apb slave side
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // timer side
  input wire logic [1:0] INT_ACK,
  input wire logic [1:0] OVF_FLAG,
  input wire logic TIMER_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic acc, ok, wr, rd;
  logic [7:0] ix;
  logic [1:0] run_ff, quiet_ff;
  logic aux_ff;
  logic [7:0] mode_ff;
  // decode of aligned in-range accesses
  assign acc = PSEL && PENABLE;
  assign ok = acc && PADDR[1:0] == 2'h0 && PADDR[11:10] == 2'h0;
  assign wr = ok && PWRITE;
  assign rd = ok && !PWRITE;
  assign ix = PADDR[9:2];
  // shadows of software bits; quiet counts idle cycles with both timers stopped
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      run_ff <= 2'h0;
      aux_ff <= 1'b0;
      mode_ff <= 8'h00;
      quiet_ff <= 2'h0;
    end else begin
      if (wr && ix == `TMR_IDX_CTRL) run_ff <= {PWDATA[6], PWDATA[4]};
      if (wr && ix == `TMR_IDX_AUX) aux_ff <= PWDATA[0];
      if (wr && ix == `TMR_IDX_MODE) mode_ff <= PWDATA[7:0];
      if ((wr && ix == `TMR_IDX_CTRL) || run_ff != 2'h0) quiet_ff <= 2'h0;
      else if (quiet_ff != 2'h3) quiet_ff <= quiet_ff + 2'h1;
    end
  end
  a_ready_high: assert property (PREADY) else $error("ready low");
  a_err_misalign: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("misaligned access not refused");
  a_err_idle: assert property (!acc |-> !PSLVERR) else $error("error outside access");
  a_aux_readback: assert property (rd && ix == `TMR_IDX_AUX |-> PRDATA == {31'h0, aux_ff})
    else $error("aux register readback wrong");
  a_mode_readback: assert property (
    rd && ix == `TMR_IDX_MODE |-> PRDATA == {24'h0, mode_ff & 8'h37})
    else $error("mode register readback wrong");
  a_ctrl_run: assert property (rd && ix == `TMR_IDX_CTRL |->
    PRDATA[6] == run_ff[1] && PRDATA[4] == run_ff[0] && PRDATA[3:0] == 4'h0)
    else $error("run bits readback wrong");
  a_flag_stopped: assert property (quiet_ff == 2'h3 |-> !$rose(OVF_FLAG[0]) && !$rose(OVF_FLAG[1]))
    else $error("flag rose while stopped");
  a_ack_clears: assert property (quiet_ff == 2'h3 && INT_ACK[0] |=> !OVF_FLAG[0])
    else $error("service did not clear flag");
  a_irq_masked: assert property (wr && ix == `TMR_IDX_IRQ_EN && PWDATA[1:0] == 2'h0
    |=> !TIMER_IRQ) else $error("masked interrupt high");
endmodule // tmr_props

bind tmr_top tmr_props i_tmr_props (.CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .INT_ACK, .OVF_FLAG, .TIMER_IRQ);

// file: rtl/tmr_cnt_if.sv
`timescale 1ns/1ps
interface tmr_cnt_if;
  tmr_pkg::tmr_mode_t mode;
  logic run_lo;
  logic run_hi;
  logic tick_lo;
  logic tick_hi;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [7:0] cnt_lo;
  logic [7:0] cnt_hi;
  logic ovf_lo;
  logic ovf_hi;

  // control side
  modport ctl (
    output mode, run_lo, run_hi, tick_lo, tick_hi, wr_lo, wr_hi, wdata,
    input cnt_lo, cnt_hi, ovf_lo, ovf_hi
  );

  // counter side
  modport cnt (
    input mode, run_lo, run_hi, tick_lo, tick_hi, wr_lo, wr_hi, wdata,
    output cnt_lo, cnt_hi, ovf_lo, ovf_hi
  );
endinterface

// file: rtl/tmr_counter.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and count
  tmr_cnt_if.cnt bus
);

  tmr_pkg::tmr_cnt_st_t st_ff;
  tmr_pkg::tmr_cnt_st_t nxt_st;

  // next count per mode, then software writes override the byte written
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ovf_lo = 1'b0;
    nxt_st.ovf_hi = 1'b0;
    unique case (bus.mode)
      tmr_pkg::TMR_M13: begin
        if (bus.run_lo && bus.tick_lo) begin
          nxt_st.lo[`TMR_PRE_BITS-1:0] = st_ff.lo[`TMR_PRE_BITS-1:0] + 5'h01;
          if (st_ff.lo[`TMR_PRE_BITS-1:0] == `TMR_PRE_TOP) begin
            nxt_st.hi = st_ff.hi + 8'h01;
            nxt_st.ovf_lo = (st_ff.hi == `TMR_BYTE_TOP);
          end
        end
      end
      tmr_pkg::TMR_M16: begin
        if (bus.run_lo && bus.tick_lo) begin
          {nxt_st.hi, nxt_st.lo} = {st_ff.hi, st_ff.lo} + 16'h0001;
          nxt_st.ovf_lo = ({st_ff.hi, st_ff.lo} == 16'hffff);
        end
      end
      tmr_pkg::TMR_RELOAD, tmr_pkg::TMR_PWM: begin
        if (bus.run_lo && bus.tick_lo) begin
          if (st_ff.lo == `TMR_BYTE_TOP) begin
            nxt_st.lo = st_ff.hi;
            nxt_st.ovf_lo = 1'b1;
          end else begin
            nxt_st.lo = st_ff.lo + 8'h01;
          end
        end
      end
      tmr_pkg::TMR_SPLIT: begin
        if (bus.run_lo && bus.tick_lo) begin
          nxt_st.lo = st_ff.lo + 8'h01;
          nxt_st.ovf_lo = (st_ff.lo == `TMR_BYTE_TOP);
        end
        if (bus.run_hi && bus.tick_hi) begin
          nxt_st.hi = st_ff.hi + 8'h01;
          nxt_st.ovf_hi = (st_ff.hi == `TMR_BYTE_TOP);
        end
      end
      tmr_pkg::TMR_HALT: begin
        nxt_st.lo = st_ff.lo;
      end
      default: begin
        nxt_st.lo = st_ff.lo;
      end
    endcase
    if (bus.wr_lo) begin
      nxt_st.lo = bus.wdata;
    end
    if (bus.wr_hi) begin
      nxt_st.hi = bus.wdata;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{lo: `TMR_RST_CNT, hi: `TMR_RST_CNT, ovf_lo: 1'b0, ovf_hi: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign bus.cnt_lo = st_ff.lo;
  assign bus.cnt_hi = st_ff.hi;
  assign bus.ovf_lo = st_ff.ovf_lo;
  assign bus.ovf_hi = st_ff.ovf_hi;

endmodule // tmr_counter

// file: rtl/tmr_params.svh
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// register indices; byte address is four times the index
`define TMR_IDX_CTRL 8'h88
`define TMR_IDX_MODE 8'h89
`define TMR_IDX_AUX 8'h8f
`define TMR_IDX_CNT0_LO 8'h90
`define TMR_IDX_CNT0_HI 8'h91
`define TMR_IDX_CNT1_LO 8'h92
`define TMR_IDX_CNT1_HI 8'h93
`define TMR_IDX_IRQ_STAT 8'h94
`define TMR_IDX_IRQ_CLR 8'h95
`define TMR_IDX_IRQ_EN 8'h96

// control register fields
`define TMR_CTRL_TF1 7
`define TMR_CTRL_TR1 6
`define TMR_CTRL_TF0 5
`define TMR_CTRL_TR0 4

// mode register fields
`define TMR_MODE_T1M1 5
`define TMR_MODE_T1M0 4
`define TMR_MODE_T0SEL 2
`define TMR_MODE_T0M1 1
`define TMR_MODE_T0M0 0
`define TMR_MODE_RMASK 8'h37

// auxiliary mode register field
`define TMR_AUX_T0_MODE_BIT2 0

// reset values
`define TMR_RST_CTRL 4'h0
`define TMR_RST_MODE 8'h00
`define TMR_RST_AUX 1'b0
`define TMR_RST_CNT 8'h00
`define TMR_RST_IRQ 2'h0

// mode 0 prescaler width and the top value of each counting byte
`define TMR_PRE_BITS 5
`define TMR_PRE_TOP 5'h1f
`define TMR_BYTE_TOP 8'hff

`endif

// file: rtl/tmr_pkg.sv
package tmr_pkg;

  // counting modes after decoding the mode code
  typedef enum logic [5:0] {
    TMR_M13 = 6'b000001,
    TMR_M16 = 6'b000010,
    TMR_RELOAD = 6'b000100,
    TMR_SPLIT = 6'b001000,
    TMR_PWM = 6'b010000,
    TMR_HALT = 6'b100000
  } tmr_mode_t;

  // state of one timer channel
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf_lo;
    logic ovf_hi;
  } tmr_cnt_st_t;

  // state of the top level
  typedef struct packed {
    logic [1:0] rst_sync;
    logic tf1;
    logic tr1;
    logic tf0;
    logic tr0;
    logic [7:0] mode_reg;
    logic aux_bit;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic pin_q;
    logic pin_prev;
    logic fall;
    logic [31:0] rdata;
  } tmr_top_st_t;

endpackage

// file: rtl/tmr_top.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_top (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // external count input of timer 0
  input wire logic EXT_COUNT_PIN,
  // interrupt service acknowledge, one bit per timer
  input wire logic [1:0] INT_ACK,
  // overflow flags and interrupt
  output logic [1:0] OVF_FLAG,
  output logic TIMER_IRQ
);

  tmr_pkg::tmr_top_st_t st_ff;
  tmr_pkg::tmr_top_st_t nxt_st;
  logic rst_n;
  logic [7:0] idx;
  logic legal;
  logic mapped;
  logic wr_en;
  logic [7:0] wbyte;
  logic t0_split;
  logic [1:0] ovf_evt;
  logic [2:0] t0_code;
  logic [2:0] t1_code;

  tmr_cnt_if cif[2] ();

  // value of every state bit under reset; pin samples start at the idle high level
  localparam tmr_pkg::tmr_top_st_t ST_RST = '{
    rst_sync: 2'b00,
    tf1: 1'b0,
    tr1: 1'b0,
    tf0: 1'b0,
    tr0: 1'b0,
    mode_reg: `TMR_RST_MODE,
    aux_bit: `TMR_RST_AUX,
    irq_stat: `TMR_RST_IRQ,
    irq_en: `TMR_RST_IRQ,
    pin_q: 1'b1,
    pin_prev: 1'b1,
    fall: 1'b0,
    rdata: 32'h0000_0000
  };

  // the rest of the block leaves reset two edges after the pin is released
  assign rst_n = st_ff.rst_sync[1];

  // mode code to counting mode
  function automatic tmr_pkg::tmr_mode_t dec_mode(input logic is_t0, input logic [2:0] code);
    tmr_pkg::tmr_mode_t m;
    m = tmr_pkg::TMR_HALT;
    case (code)
      3'h0: m = tmr_pkg::TMR_M13;
      3'h1: m = tmr_pkg::TMR_M16;
      3'h2: m = tmr_pkg::TMR_RELOAD;
      3'h3: m = is_t0 ? tmr_pkg::TMR_SPLIT : tmr_pkg::TMR_HALT;
      3'h6: m = tmr_pkg::TMR_PWM;
      default: m = tmr_pkg::TMR_HALT;
    endcase
    return m;
  endfunction

  // address decode; only whole aligned words inside the low 1 kB
  assign idx = PADDR[9:2];
  assign legal = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);
  always_comb begin
    mapped = 1'b0;
    if (legal) begin
      case (idx)
        `TMR_IDX_CTRL, `TMR_IDX_MODE, `TMR_IDX_AUX: mapped = 1'b1;
        `TMR_IDX_CNT0_LO, `TMR_IDX_CNT0_HI: mapped = 1'b1;
        `TMR_IDX_CNT1_LO, `TMR_IDX_CNT1_HI: mapped = 1'b1;
        `TMR_IDX_IRQ_STAT, `TMR_IDX_IRQ_CLR, `TMR_IDX_IRQ_EN: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end
  assign wr_en = PSEL && PENABLE && PWRITE && mapped;
  assign wbyte = PWDATA[7:0];

  // zero-wait answer, error on unmapped access
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = st_ff.rdata;

  // mode codes of both timers
  assign t0_code = {st_ff.aux_bit, st_ff.mode_reg[`TMR_MODE_T0M1],
                    st_ff.mode_reg[`TMR_MODE_T0M0]};
  assign t1_code = {1'b0, st_ff.mode_reg[`TMR_MODE_T1M1], st_ff.mode_reg[`TMR_MODE_T1M0]};
  assign t0_split = (cif[0].mode == tmr_pkg::TMR_SPLIT);

  // timer 0: own run bit, pin edges or clock; split high byte borrows timer 1 run bit
  assign cif[0].mode = dec_mode(1'b1, t0_code);
  assign cif[0].run_lo = st_ff.tr0;
  assign cif[0].run_hi = st_ff.tr1;
  assign cif[0].tick_lo = st_ff.mode_reg[`TMR_MODE_T0SEL] ? st_ff.fall : 1'b1;
  assign cif[0].tick_hi = 1'b1;
  assign cif[0].wr_lo = wr_en && (idx == `TMR_IDX_CNT0_LO);
  assign cif[0].wr_hi = wr_en && (idx == `TMR_IDX_CNT0_HI);
  assign cif[0].wdata = wbyte;

  // timer 1: timer function only
  assign cif[1].mode = dec_mode(1'b0, t1_code);
  assign cif[1].run_lo = st_ff.tr1;
  assign cif[1].run_hi = 1'b0;
  assign cif[1].tick_lo = 1'b1;
  assign cif[1].tick_hi = 1'b0;
  assign cif[1].wr_lo = wr_en && (idx == `TMR_IDX_CNT1_LO);
  assign cif[1].wr_hi = wr_en && (idx == `TMR_IDX_CNT1_HI);
  assign cif[1].wdata = wbyte;

  // one counter per timer
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    tmr_counter u_cnt (
      .clk(CLK),
      .rst_n(rst_n),
      .bus(cif[g])
    );
  end

  // overflow events; split timer 0 takes over timer 1's flag
  assign ovf_evt[0] = cif[0].ovf_lo;
  assign ovf_evt[1] = t0_split ? cif[0].ovf_hi : cif[1].ovf_lo;

  // next state: registers, flags, pin sampling and read data
  always_comb begin
    nxt_st = st_ff;
    // pin sampled each cycle; edge counted in the cycle after detection
    nxt_st.pin_q = EXT_COUNT_PIN;
    nxt_st.pin_prev = st_ff.pin_q;
    nxt_st.fall = st_ff.pin_prev && !st_ff.pin_q;
    // control register writes; run bits only gate, never clear counts
    if (wr_en && (idx == `TMR_IDX_CTRL)) begin
      nxt_st.tf1 = wbyte[`TMR_CTRL_TF1];
      nxt_st.tr1 = wbyte[`TMR_CTRL_TR1];
      nxt_st.tf0 = wbyte[`TMR_CTRL_TF0];
      nxt_st.tr0 = wbyte[`TMR_CTRL_TR0];
    end
    // service acknowledge clears, hardware set wins over any clear
    if (INT_ACK[0]) begin
      nxt_st.tf0 = 1'b0;
    end
    if (INT_ACK[1]) begin
      nxt_st.tf1 = 1'b0;
    end
    if (ovf_evt[0]) begin
      nxt_st.tf0 = 1'b1;
    end
    if (ovf_evt[1]) begin
      nxt_st.tf1 = 1'b1;
    end
    // mode registers
    if (wr_en && (idx == `TMR_IDX_MODE)) begin
      nxt_st.mode_reg = wbyte & `TMR_MODE_RMASK;
    end
    if (wr_en && (idx == `TMR_IDX_AUX)) begin
      nxt_st.aux_bit = wbyte[`TMR_AUX_T0_MODE_BIT2];
    end
    // sticky interrupt status with write-one-to-clear, set wins
    if (wr_en && (idx == `TMR_IDX_IRQ_CLR)) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~wbyte[1:0];
    end
    nxt_st.irq_stat = nxt_st.irq_stat | ovf_evt;
    if (wr_en && (idx == `TMR_IDX_IRQ_EN)) begin
      nxt_st.irq_en = wbyte[1:0];
    end
    // read data captured in the setup cycle
    if (PSEL && !PENABLE && !PWRITE) begin
      nxt_st.rdata = 32'h0000_0000;
      if (legal) begin
        case (idx)
          `TMR_IDX_CTRL: nxt_st.rdata[7:4] = {st_ff.tf1, st_ff.tr1, st_ff.tf0, st_ff.tr0};
          `TMR_IDX_MODE: nxt_st.rdata[7:0] = st_ff.mode_reg;
          `TMR_IDX_AUX: nxt_st.rdata[0] = st_ff.aux_bit;
          `TMR_IDX_CNT0_LO: nxt_st.rdata[7:0] = cif[0].cnt_lo;
          `TMR_IDX_CNT0_HI: nxt_st.rdata[7:0] = cif[0].cnt_hi;
          `TMR_IDX_CNT1_LO: nxt_st.rdata[7:0] = cif[1].cnt_lo;
          `TMR_IDX_CNT1_HI: nxt_st.rdata[7:0] = cif[1].cnt_hi;
          `TMR_IDX_IRQ_STAT: nxt_st.rdata[1:0] = st_ff.irq_stat;
          `TMR_IDX_IRQ_EN: nxt_st.rdata[1:0] = st_ff.irq_en;
          default: nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    // held in reset until the synchroniser output rises; the synchroniser shifts in ones
    if (!rst_n) begin
      nxt_st = ST_RST;
    end
    nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
  end

  // state register; the pin clears it at once, one process drives the whole struct
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // flags and interrupt out
  assign OVF_FLAG = {st_ff.tf1, st_ff.tf0};
  assign TIMER_IRQ = |(st_ff.irq_stat & st_ff.irq_en);

endmodule // tmr_top
